// ==== core/adfr_top.sv ====
`timescale 1ns/10ps
module adfr_top (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic dec_word_wr,
    input wire logic [7:0] dec_word_data,
    input wire adfr_pkg::adfr_mode_t mode,
    input wire adfr_pkg::adfr_refcfg_t ref_cfg,
    input wire adfr_pkg::adfr_burn_t burn_cfg,
    input wire logic cal_start,
    input wire logic cal_gain,
    input wire logic cal_aux,
    input wire logic err_clear,
    input wire logic mod_clk_pin,
    input wire logic mod_bit_pin,
    input wire logic ref_float_pos_pin,
    input wire logic ref_float_neg_pin,
    input wire logic ref_low_pin,
    output logic [7:0] decimation_word,
    output logic [7:0] decimation_eff,
    output logic [23:0] result_data,
    output logic result_valid,
    output logic cal_wr,
    output logic cal_wr_gain,
    output logic cal_wr_aux,
    output logic [23:0] cal_wr_data,
    output adfr_pkg::adfr_status_t status,
    output adfr_pkg::adfr_refcfg_t ref_route,
    output logic [1:0] range_halved,
    output logic burnout_drive
);
    localparam int AW = adfr_pkg::ACC_W;

    logic [2:0] mclk_s;
    logic [1:0] mbit_s;
    logic [1:0] fpos_s;
    logic [1:0] fneg_s;
    logic [1:0] low_s;
    logic tick;
    logic dly_bit;
    logic [1:0] x_in;
    logic [10:0] tick_cnt;
    logic dec_evt;
    logic [1:0] chop_phase;
    logic conv_done;
    logic [AW-1:0] i1, i2, i3, z1, z2, z3;
    logic [AW-1:0] d1, d2, d3;
    logic ref_bad;
    adfr_pkg::adfr_cal_state_t cal_state;
    logic set_err;

    // pins from the analog side get two flops before use
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mclk_s <= 3'h0;
            mbit_s <= 2'h0;
            fpos_s <= 2'h0;
            fneg_s <= 2'h0;
            low_s <= 2'h0;
        end else begin
            mclk_s <= {mclk_s[1:0], mod_clk_pin};
            mbit_s <= {mbit_s[0], mod_bit_pin};
            fpos_s <= {fpos_s[0], ref_float_pos_pin};
            fneg_s <= {fneg_s[0], ref_float_neg_pin};
            low_s <= {low_s[0], ref_low_pin};
        end
    end

    assign tick = mclk_s[1] & ~mclk_s[2];
    assign ref_bad = fpos_s[1] | fneg_s[1] | low_s[1];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            decimation_word <= adfr_pkg::DEC_WORD_RST;
        end else if (dec_word_wr) begin
            decimation_word <= dec_word_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            decimation_eff <= adfr_pkg::DEC_WORD_RST;
        end else begin
            decimation_eff <= adfr_pkg::eff_word(decimation_word, mode.chop_enable);
        end
    end

    // comb zero half a 60 Hz period back
    adfr_delay_mem u_notch (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .step(tick),
        .din(mbit_s[1]),
        .dout(dly_bit)
    );

    // both paths carry gain two so the word scale does not jump with the notch
    assign x_in = mode.mains_notch_enable ? {1'b0, mbit_s[1]} + {1'b0, dly_bit}
                                          : {mbit_s[1], 1'b0};

    // integrators run at the modulator rate
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            i1 <= '0;
            i2 <= '0;
            i3 <= '0;
        end else if (tick) begin
            i1 <= i1 + AW'(x_in);
            i2 <= i2 + i1;
            i3 <= i3 + i2;
        end
    end

    // decimation counter, eight ticks per word step
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tick_cnt <= 11'h000;
        end else if (tick) begin
            tick_cnt <= dec_evt ? 11'h000 : tick_cnt + 11'h001;
        end
    end

    assign dec_evt = tick && tick_cnt >= adfr_pkg::last_tick(decimation_eff);

    // wrap-around arithmetic: comb differences stay exact modulo 2^AW
    always_comb begin
        d1 = i3 - z1;
        d2 = d1 - z2;
        d3 = d2 - z3;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            z1 <= '0;
            z2 <= '0;
            z3 <= '0;
        end else if (dec_evt) begin
            z1 <= i3;
            z2 <= d1;
            z3 <= d2;
        end
    end

    // chop: one output per three filter words
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            chop_phase <= 2'h0;
        end else if (!mode.chop_enable) begin
            chop_phase <= 2'h0;
        end else if (dec_evt) begin
            chop_phase <= (chop_phase == adfr_pkg::CHOP_LAST_PHASE) ? 2'h0 : chop_phase + 2'h1;
        end
    end

    assign conv_done = dec_evt && (!mode.chop_enable || chop_phase == adfr_pkg::CHOP_LAST_PHASE);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            result_valid <= 1'b0;
            result_data <= '0;
        end else begin
            result_valid <= conv_done;
            if (conv_done) begin
                result_data <= ref_bad ? adfr_pkg::CLAMP_VALUE
                                       : d3[adfr_pkg::RES_LSB +: adfr_pkg::RES_W];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            status.missing_reference_flag <= 1'b0;
        end else begin
            status.missing_reference_flag <= ref_bad;
        end
    end

    // calibration waits for a normal conversion at the user word
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cal_state <= adfr_pkg::CAL_IDLE;
            cal_wr_gain <= 1'b0;
            cal_wr_aux <= 1'b0;
        end else begin
            case (cal_state)
                adfr_pkg::CAL_IDLE: begin
                    if (cal_start) begin
                        cal_state <= adfr_pkg::CAL_RUN;
                        cal_wr_gain <= cal_gain;
                        cal_wr_aux <= cal_aux;
                    end
                end
                adfr_pkg::CAL_RUN: begin
                    if (ref_bad || conv_done) begin
                        cal_state <= adfr_pkg::CAL_IDLE;
                    end
                end
                default: cal_state <= adfr_pkg::CAL_IDLE;
            endcase
        end
    end

    assign set_err = cal_state == adfr_pkg::CAL_RUN && ref_bad;

    // write only with a good reference
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cal_wr <= 1'b0;
            cal_wr_data <= '0;
        end else begin
            cal_wr <= cal_state == adfr_pkg::CAL_RUN && conv_done && !ref_bad;
            if (cal_state == adfr_pkg::CAL_RUN && conv_done) begin
                cal_wr_data <= d3[adfr_pkg::RES_LSB +: adfr_pkg::RES_W];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            status.cal_busy <= 1'b0;
        end else begin
            status.cal_busy <= cal_state == adfr_pkg::CAL_RUN && !ref_bad && !conv_done
                               || cal_state == adfr_pkg::CAL_IDLE && cal_start;
        end
    end

    // sticky error bits; a new error wins over a clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            status.primary_cal_error <= 1'b0;
            status.auxiliary_cal_error <= 1'b0;
        end else begin
            status.primary_cal_error <= (status.primary_cal_error & ~err_clear)
                                        | (set_err & ~cal_wr_aux);
            status.auxiliary_cal_error <= (status.auxiliary_cal_error & ~err_clear)
                                          | (set_err & cal_wr_aux);
        end
    end

    // reference routing; auxiliary has no second-reference path
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ref_route <= '0;
            range_halved <= 2'h0;
        end else begin
            ref_route <= ref_cfg;
            range_halved <= {ref_cfg.aux_bandgap, ref_cfg.primary_bandgap};
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            burnout_drive <= 1'b0;
        end else begin
            burnout_drive <= burn_cfg.enable && burn_cfg.differential && burn_cfg.buffered
                             && (burn_cfg.pair == adfr_pkg::CH_PAIR_56
                                 || burn_cfg.pair == adfr_pkg::CH_PAIR_78);
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    chop_clamp_a: assert property (mode.chop_enable && decimation_word < 8'h0d
        ##1 mode.chop_enable |-> decimation_eff == 8'h0d)
        else $error("chop word not clamped to 13");
    plain_range_a: assert property (!mode.chop_enable && decimation_word >= 8'h03
        ##1 !mode.chop_enable && $stable(decimation_word)
        |-> decimation_eff == $past(decimation_word))
        else $error("plain word not used as written");
    reset_word_a: assert property (disable iff (1'b0) $past(sys_rst) |-> decimation_word == 8'h45)
        else $error("decimation word reset value wrong");
    // counter bound
    // a smaller word leaves the count high until the next tick, up to eight cycles later
    tick_bound_a: assert property (
        $stable(decimation_eff) [*8] ##1 $stable(decimation_eff)
        |-> tick_cnt <= 11'(({3'b000, decimation_eff} * 11'h008) - 11'h001))
        else $error("decimation counter overran eight ticks per word");
    ref_flag_a: assert property ($rose(fpos_s[1]) ##1 fpos_s[1] |-> status.missing_reference_flag)
        else $error("missing reference flag not set");
    result_clamp_a: assert property (result_valid && $past(ref_bad) |-> result_data == 24'hffffff)
        else $error("result not clamped without reference");
    cal_block_a: assert property (cal_state == adfr_pkg::CAL_RUN && ref_bad |=> !cal_wr
        && (status.primary_cal_error || status.auxiliary_cal_error) ##1 !status.cal_busy)
        else $error("calibration write not blocked");
    burnout_gate_a: assert property (burnout_drive |-> $past(burn_cfg.buffered)
        && $past(burn_cfg.differential) && $past(burn_cfg.enable))
        else $error("burnout driven without buffer");

    conv_seen_c: cover property (result_valid ##1 !result_valid);
    cal_write_c: cover property (cal_wr);
    cal_error_c: cover property ($rose(status.primary_cal_error));
    burnout_on_c: cover property ($rose(burnout_drive));
endmodule : adfr_top

// ==== core/adfr_pkg.sv ====
package adfr_pkg;
    // decimation word after reset (69 decimal)
    localparam logic [7:0] DEC_WORD_RST = 8'h45;
    localparam logic [7:0] DEC_MIN_PLAIN = 8'h03;
    localparam logic [7:0] DEC_MIN_CHOP = 8'h0d;
    // modulator clocks per decimation word step: 8 x 30.5 us = 0.244 ms
    localparam logic [10:0] TICKS_PER_WORD = 11'h008;
    // half a 60 Hz period in 32.768 kHz modulator clocks
    localparam logic [9:0] NOTCH_TAPS = 10'h111;
    localparam logic [1:0] CHOP_LAST_PHASE = 2'h2;
    localparam int ACC_W = 36;
    localparam int RES_W = 24;
    localparam int RES_LSB = 11;
    localparam logic [RES_W-1:0] CLAMP_VALUE = 24'hffffff;
    localparam logic [3:0] CH_PAIR_56 = 4'h2;
    localparam logic [3:0] CH_PAIR_78 = 4'h3;

    typedef struct packed {
        logic chop_enable;
        logic mains_notch_enable;
    } adfr_mode_t;

    typedef struct packed {
        logic primary_second_ref;
        logic primary_bandgap;
        logic aux_bandgap;
    } adfr_refcfg_t;

    typedef struct packed {
        logic enable;
        logic differential;
        logic buffered;
        logic [3:0] pair;
    } adfr_burn_t;

    typedef struct packed {
        logic missing_reference_flag;
        logic primary_cal_error;
        logic auxiliary_cal_error;
        logic cal_busy;
    } adfr_status_t;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN = 2'b01
    } adfr_cal_state_t;

    function automatic logic [7:0] eff_word(input logic [7:0] w, input logic chop);
        if (chop && w < DEC_MIN_CHOP) begin
            eff_word = DEC_MIN_CHOP;
        end else if (w < DEC_MIN_PLAIN) begin
            eff_word = DEC_MIN_PLAIN;
        end else begin
            eff_word = w;
        end
    endfunction : eff_word

    function automatic logic [10:0] last_tick(input logic [7:0] w);
        last_tick = 11'(({3'b000, w} * TICKS_PER_WORD) - 11'h001);
    endfunction : last_tick
endpackage : adfr_pkg

// ==== core/adfr_delay_mem.sv ====
`timescale 1ns/10ps
module adfr_delay_mem (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic step,
    input wire logic din,
    output logic dout
);
    logic mem [0:511];
    logic [9:0] addr;

    // ring of NOTCH_TAPS entries: each step reads the oldest bit, then overwrites it
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            addr <= 10'h000;
        end else if (step) begin
            addr <= (addr == adfr_pkg::NOTCH_TAPS - 10'h001) ? 10'h000 : addr + 10'h001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (step) begin
            mem[addr[8:0]] <= din;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dout <= 1'b0;
        end else if (step) begin
            dout <= mem[addr[8:0]];
        end
    end
endmodule : adfr_delay_mem

// ==== tb/adfr_sensor_model.sv ====
`timescale 1ns/10ps
module adfr_sensor_model #(
    parameter int HALF_NS = 40
) (
    input wire logic level,
    input wire logic [2:0] fault,
    output logic mod_clk_pin,
    output logic mod_bit_pin,
    output logic ref_float_pos_pin,
    output logic ref_float_neg_pin,
    output logic ref_low_pin
);
    initial begin
        mod_clk_pin = 1'b0;
        mod_bit_pin = 1'b0;
    end
    // free-running modulator clock
    // sped up from the real rate so that conversions fit a short run
    always #(HALF_NS) mod_clk_pin = ~mod_clk_pin;
    // comparator bit stream
    // level 1 stands for an open sensor at full scale, 0 for a short
    always @(negedge mod_clk_pin) begin
        mod_bit_pin <= level;
    end
    assign ref_float_pos_pin = fault[0];
    assign ref_float_neg_pin = fault[1];
    assign ref_low_pin = fault[2];
endmodule : adfr_sensor_model

// ==== tb/adfr_top_test.sv ====
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
    end \
end
module adfr_top_test;
    logic core_clk;
    logic sys_rst;
    logic dec_word_wr;
    logic [7:0] dec_word_data;
    adfr_pkg::adfr_mode_t mode;
    adfr_pkg::adfr_refcfg_t ref_cfg;
    adfr_pkg::adfr_burn_t burn_cfg;
    logic cal_start;
    logic cal_gain;
    logic cal_aux;
    logic err_clear;
    logic mod_clk_pin;
    logic mod_bit_pin;
    logic ref_float_pos_pin;
    logic ref_float_neg_pin;
    logic ref_low_pin;
    logic [7:0] decimation_word;
    logic [7:0] decimation_eff;
    logic [23:0] result_data;
    logic result_valid;
    logic cal_wr;
    logic cal_wr_gain;
    logic cal_wr_aux;
    logic [23:0] cal_wr_data;
    adfr_pkg::adfr_status_t status;
    adfr_pkg::adfr_refcfg_t ref_route;
    logic [1:0] range_halved;
    logic burnout_drive;
    logic level;
    logic [2:0] fault;
    int errors = 0;
    int cmp_count = 0;

    adfr_top uut (.core_clk, .sys_rst, .dec_word_wr, .dec_word_data, .mode, .ref_cfg,
        .burn_cfg, .cal_start, .cal_gain, .cal_aux, .err_clear, .mod_clk_pin, .mod_bit_pin,
        .ref_float_pos_pin, .ref_float_neg_pin, .ref_low_pin, .decimation_word,
        .decimation_eff, .result_data, .result_valid, .cal_wr, .cal_wr_gain, .cal_wr_aux,
        .cal_wr_data, .status, .ref_route, .range_halved, .burnout_drive);
    adfr_sensor_model #(.HALF_NS(40)) far_side (.level, .fault, .mod_clk_pin, .mod_bit_pin,
        .ref_float_pos_pin, .ref_float_neg_pin, .ref_low_pin);

    always #5 core_clk = ~core_clk;

    task automatic give_verdict();
        if (errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    task automatic set_word(input logic [7:0] w, input logic chop);
        mode.chop_enable = chop;
        dec_word_data = w;
        dec_word_wr = 1'b1;
        step(1);
        dec_word_wr = 1'b0;
    endtask : set_word

    // bounded wait for the next result; n counts the cycles waited
    task automatic wait_res(output logic [23:0] d, output int n);
        for (n = 1; n < 20000; n++) begin
            step(1);
            if (result_valid === 1'b1) begin
                d = result_data;
                return;
            end
        end
        errors++;
        give_verdict();
    endtask : wait_res

    // sinc3 needs four results to settle after a change
    task automatic settle(output logic [23:0] d);
        int n;
        repeat (4) wait_res(d, n);
    endtask : settle

    task automatic chk_words();
        logic [7:0] w [8] = '{8'h00, 8'h02, 8'h03, 8'hff, 8'h02, 8'h0c, 8'h0d, 8'h0e};
        logic [7:0] e [8] = '{8'h03, 8'h03, 8'h03, 8'hff, 8'h0d, 8'h0d, 8'h0d, 8'h0e};
        for (int i = 0; i < 8; i++) begin
            set_word(w[i], i > 3);
            `CHK(decimation_word, w[i])
            step(1);
            `CHK(decimation_eff, e[i])
        end
    endtask : chk_words

    task automatic chk_refs();
        for (int i = 0; i < 8; i++) begin
            ref_cfg = 3'(i);
            step(2);
            `CHK(ref_route, ref_cfg)
            `CHK(range_halved, {ref_cfg.aux_bandgap, ref_cfg.primary_bandgap})
            `CHK(status.missing_reference_flag, 1'b0)
        end
    endtask : chk_refs

    task automatic chk_burn();
        logic exp;
        for (int i = 0; i < 128; i++) begin
            burn_cfg = 7'(i);
            step(2);
            exp = burn_cfg.pair == adfr_pkg::CH_PAIR_56 || burn_cfg.pair == adfr_pkg::CH_PAIR_78;
            exp = exp & burn_cfg.enable & burn_cfg.differential & burn_cfg.buffered;
            `CHK(burnout_drive, exp)
        end
    endtask : chk_burn

    // eight modulator ticks of 8 core cycles per word step
    task automatic chk_period(input logic [7:0] w, input logic chop, input int exp);
        logic [23:0] d;
        int n;
        set_word(w, chop);
        repeat (3) wait_res(d, n);
        `CHK(n, exp)
    endtask : chk_period

    task automatic chk_duty();
        logic [23:0] r0;
        logic [23:0] r1;
        logic [23:0] rn;
        set_word(8'h03, 1'b0);
        level = 1'b0;
        settle(r0);
        level = 1'b1;
        settle(r1);
        `CHK(r1 != r0, 1'b1)
        // notch only with a word of 68 or more
        set_word(8'h44, 1'b0);
        settle(r1);
        // full scale at word 68: two times (8 x 68)^3, cut by the result shift
        `CHK(r1, 24'h026620)
        mode.mains_notch_enable = 1'b1;
        settle(rn);
        // both filter paths carry gain two, so a steady level reads the same
        `CHK(rn, 24'h026620)
        mode.mains_notch_enable = 1'b0;
    endtask : chk_duty

    task automatic chk_fault();
        logic [23:0] d;
        int n;
        set_word(8'h03, 1'b0);
        for (int i = 0; i < 3; i++) begin
            fault = 3'h1 << i;
            step(4);
            `CHK(status.missing_reference_flag, 1'b1)
            wait_res(d, n);
            `CHK(d, 24'hffffff)
            fault = 3'h0;
            step(4);
            `CHK(status.missing_reference_flag, 1'b0)
        end
    endtask : chk_fault

    task automatic chk_cal();
        int n;
        for (int k = 0; k < 4; k++) begin
            cal_gain = k[0];
            cal_aux = k[1];
            cal_start = 1'b1;
            step(1);
            cal_start = 1'b0;
            `CHK(status.cal_busy, 1'b1)
            for (n = 0; n < 200 && cal_wr !== 1'b1; n++) step(1);
            `CHK(n < 200, 1'b1)
            if (n >= 200) begin
                give_verdict();
            end
            `CHK(result_valid, 1'b1)
            // settled full scale at word 3: two times (8 x 3)^3, cut by the result shift
            `CHK(cal_wr_data, 24'h00000d)
            `CHK(result_data, 24'h00000d)
            `CHK({cal_wr_gain, cal_wr_aux}, {k[0], k[1]})
            step(1);
            `CHK({cal_wr, status.primary_cal_error, status.auxiliary_cal_error}, 3'h0)
        end
    endtask : chk_cal

    task automatic chk_cal_err();
        logic seen;
        set_word(8'h45, 1'b0);
        for (int k = 0; k < 2; k++) begin
            cal_aux = k[0];
            cal_gain = ~k[0];
            cal_start = 1'b1;
            step(1);
            cal_start = 1'b0;
            step(20);
            fault = 3'h4;
            seen = 1'b0;
            repeat (8) begin
                step(1);
                seen = seen | cal_wr;
            end
            `CHK(seen, 1'b0)
            `CHK(status.cal_busy, 1'b0)
            `CHK({status.primary_cal_error, status.auxiliary_cal_error}, {~k[0], k[0]})
            fault = 3'h0;
            step(4);
            err_clear = 1'b1;
            step(1);
            err_clear = 1'b0;
            step(1);
            `CHK({status.primary_cal_error, status.auxiliary_cal_error}, 2'h0)
        end
    endtask : chk_cal_err

    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        dec_word_wr = 1'b0;
        dec_word_data = 8'h00;
        mode = '0;
        ref_cfg = '0;
        burn_cfg = '0;
        cal_start = 1'b0;
        cal_gain = 1'b0;
        cal_aux = 1'b0;
        err_clear = 1'b0;
        level = 1'b0;
        fault = 3'h0;
        step(12);
        sys_rst = 1'b0;
        step(1);
        `CHK({decimation_word, decimation_eff}, 16'h4545)
        `CHK({result_valid, cal_wr, status}, 6'h00)
        chk_words();
        chk_refs();
        chk_burn();
        chk_period(8'h03, 1'b0, 192);
        chk_period(8'h04, 1'b0, 256);
        chk_period(8'h05, 1'b1, 2496);
        chk_duty();
        chk_fault();
        chk_cal();
        chk_cal_err();
        give_verdict();
    end
endmodule : adfr_top_test
